// ---- identity_scratch_register_bank_tb.sv ----
`timescale 1ns/1ps
module identity_scratch_register_bank_tb;
    localparam int FLASH_CYC = 600;
    localparam logic [15:0] PCODE = 16'h3c3c; // arbitrary value
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sclk, cs_n, din, dout, cmd_busy;
    int num_errors = 0;
    int tests_run = 0;
    int busy_run = 0;
    int last_run = 0;
    int mdl [int];
    logic [31:0] seed = 32'd20178;
    always #2 clk = ~clk;
    isr_bank #(.FLASH_UPDATE_CYCLES(FLASH_CYC), .PRODUCT_CODE(PCODE), .DATE_MD(16'h1127),
        .DATE_Y(16'h2017), .LOT_SERIAL(16'h0815)) u_dut (.clk(clk), .nrst(nrst),
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .cmd_busy(cmd_busy));
    isr_host_model u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
    // length of the latest busy stretch, in clocks
    always @(posedge clk) begin
        if (cmd_busy === 1'b1) busy_run <= busy_run + 1;
        else if (busy_run != 0) begin
            last_run <= busy_run;
            busy_run <= 0;
        end
    end
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // answer comes back in the following frame
    task automatic rd(input logic [6:0] a, input string nm);
        logic [15:0] r;
        u_host.xfer({1'b0, a, 8'h00}, r);
        u_host.xfer(16'h0000, r);
        check(nm, r, 16'(mdl[int'(a)]));
    endtask : rd
    task automatic wait_idle();
        for (int i = 0; i < 2000 && cmd_busy !== 1'b0; i++) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask : wait_idle
    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    initial begin
        logic [15:0] v;
        mdl[0] = 0;
        mdl[int'(isr_pkg::ADDR_DATE_MD)] = 16'h1127;
        mdl[int'(isr_pkg::ADDR_DATE_Y)] = 16'h2017;
        mdl[int'(isr_pkg::ADDR_PROD)] = PCODE;
        mdl[int'(isr_pkg::ADDR_SERIAL)] = 16'h0815;
        mdl[int'(isr_pkg::ADDR_FC_LO)] = 0;
        mdl[int'(isr_pkg::ADDR_FC_HI)] = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        wait_idle();
        rd(isr_pkg::ADDR_DATE_MD, "date_md");
        rd(isr_pkg::ADDR_DATE_Y, "date_y");
        rd(isr_pkg::ADDR_PROD, "product");
        rd(isr_pkg::ADDR_SERIAL, "serial");
        rd(7'h00, "unmapped");
        u_host.wr(isr_pkg::ADDR_PROD, rnd());
        u_host.wr(isr_pkg::ADDR_FC_LO, rnd());
        rd(isr_pkg::ADDR_PROD, "product_ro");
        rd(isr_pkg::ADDR_FC_LO, "count_lo_ro");
        for (int k = 0; k < isr_pkg::NUM_SCR; k++) begin
            v = rnd();
            mdl[int'(isr_pkg::ADDR_SCR_A) + 2 * k] = v;
            u_host.wr(isr_pkg::ADDR_SCR_A + 7'(2 * k), v);
        end
        for (int k = 0; k < isr_pkg::NUM_SCR; k++) begin
            rd(isr_pkg::ADDR_SCR_A + 7'(2 * k), "scr");
        end
        // poke while busy, then keep the scratch words over a reset
        u_host.wr(isr_pkg::ADDR_CMD, 16'h0008);
        u_host.xfer({1'b1, isr_pkg::ADDR_SCR_A, 8'h55}, v);
        wait_idle();
        // busy stands exactly as many clocks as the update length
        check("busy_len", 16'(last_run), 16'(FLASH_CYC));
        mdl[int'(isr_pkg::ADDR_FC_LO)] = 1;
        rd(isr_pkg::ADDR_SCR_A, "scr_busy");
        rd(isr_pkg::ADDR_FC_LO, "count_lo");
        rd(isr_pkg::ADDR_FC_HI, "count_hi");
        @(posedge clk) nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        wait_idle();
        for (int k = 0; k < isr_pkg::NUM_SCR; k++) begin
            rd(isr_pkg::ADDR_SCR_A + 7'(2 * k), "scr_kept");
        end
        rd(isr_pkg::ADDR_FC_LO, "count_kept");
        complete_run();
    end
endmodule : identity_scratch_register_bank_tb

// ---- isr_bank.sv ----
`timescale 1ns/1ps
module isr_bank #(
    parameter int unsigned FLASH_UPDATE_CYCLES = isr_pkg::FLASH_UPDATE_CYCLES,
    parameter logic [15:0] PRODUCT_CODE = 16'h5a5a, // arbitrary value
    parameter logic [15:0] DATE_MD = 16'h0101,
    parameter logic [15:0] DATE_Y = 16'h2000,
    parameter logic [15:0] LOT_SERIAL = 16'h0001
) (
    input wire logic clk, // core clock
    input wire logic nrst, // async reset, active low
    input wire logic sclk, // serial clock pin
    input wire logic cs_n, // serial chip select pin, active low
    input wire logic din, // serial data in pin
    output logic dout, // serial data out pin
    output logic cmd_busy // high while loading or running a flash update
);
    isr_pkg::isr_state_type st;
    isr_pkg::isr_state_type next_st;
    logic sclk_s1, sclk_s2, sclk_d;
    logic cs_s1, cs_s2, cs_d;
    logic din_s1, din_s2;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [4:0] bit_cnt;
    logic [6:0] rd_addr;
    logic [15:0] date_md, date_y, prod, serial;
    logic [isr_pkg::NUM_SCR-1:0][15:0] scr;
    logic [31:0] fcnt;
    logic [31:0] upd_cnt;
    localparam logic [31:0] CNT_ONE_L = isr_pkg::CNT_ONE;
    // stored copies; they survive nrst the way flash survives a reset
    // power-up content is zero, as an erased store would read
    logic [15:0] nv_scr [isr_pkg::NUM_SCR] = '{default: isr_pkg::WORD_ZERO};
    logic [31:0] nv_fcnt = 32'h0000_0000;

    // pin synchronisers; only stage two and later feed logic
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {sclk_s1, sclk_s2, sclk_d} <= 3'h7;
            {cs_s1, cs_s2, cs_d} <= 3'h7;
            {din_s1, din_s2} <= 2'h0;
        end else begin
            {sclk_s1, sclk_s2, sclk_d} <= {sclk, sclk_s1, sclk_s2};
            {cs_s1, cs_s2, cs_d} <= {cs_n, cs_s1, cs_s2};
            {din_s1, din_s2} <= {din, din_s1};
        end
    end

    wire sclk_rise = sclk_s2 & ~sclk_d;
    wire sclk_fall = ~sclk_s2 & sclk_d;
    wire cs_start = ~cs_s2 & cs_d;
    wire cs_end = cs_s2 & ~cs_d;
    wire idle = (st == isr_pkg::ST_IDLE);
    // frames that arrive while busy are dropped whole
    wire frame_done = cs_end & (bit_cnt == isr_pkg::FRAME_LEN) & idle;
    wire frame_wr = frame_done & rx[isr_pkg::WR_FLAG_BIT];
    wire frame_rd = frame_done & ~rx[isr_pkg::WR_FLAG_BIT];
    wire [6:0] wr_addr = rx[isr_pkg::ADDR_MSB:isr_pkg::ADDR_LSB];
    wire [7:0] wr_byte = rx[7:0];
    wire [6:0] wr_word = {wr_addr[6:1], 1'b0};
    wire start_update = frame_wr & (wr_addr == isr_pkg::ADDR_CMD)
        & wr_byte[isr_pkg::CMD_FLASH_BIT];
    wire upd_last = (upd_cnt == FLASH_UPDATE_CYCLES - 1);
    wire [31:0] fcnt_inc = fcnt + isr_pkg::CNT_ONE;

    // read selection; low address bit ignored, unmapped words read zero
    logic [15:0] rd_word;
    always_comb begin
        unique case ({rd_addr[6:1], 1'b0})
            isr_pkg::ADDR_DATE_MD: rd_word = date_md;
            isr_pkg::ADDR_DATE_Y: rd_word = date_y;
            isr_pkg::ADDR_PROD: rd_word = prod;
            isr_pkg::ADDR_SERIAL: rd_word = serial;
            isr_pkg::ADDR_SCR_A: rd_word = scr[0];
            isr_pkg::ADDR_SCR_B: rd_word = scr[1];
            isr_pkg::ADDR_SCR_C: rd_word = scr[2];
            isr_pkg::ADDR_FC_LO: rd_word = fcnt[15:0];
            isr_pkg::ADDR_FC_HI: rd_word = fcnt[31:16];
            default: rd_word = isr_pkg::WORD_ZERO;
        endcase
    end

    always_comb begin
        next_st = st;
        unique case (st)
            isr_pkg::ST_LOAD: next_st = isr_pkg::ST_IDLE;
            isr_pkg::ST_IDLE: if (start_update) next_st = isr_pkg::ST_UPDATE;
            isr_pkg::ST_UPDATE: if (upd_last) next_st = isr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= isr_pkg::ST_LOAD;
            cmd_busy <= 1'b1;
            upd_cnt <= 32'h0000_0000;
        end else begin
            st <= next_st;
            cmd_busy <= (next_st != isr_pkg::ST_IDLE);
            upd_cnt <= (st == isr_pkg::ST_UPDATE) ? upd_cnt + CNT_ONE_L : 32'h0000_0000;
        end
    end

    // receive shifter; frames shorter or longer than 16 bits are dropped
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx <= isr_pkg::WORD_ZERO;
            bit_cnt <= 5'h00;
        end else if (cs_start) begin
            bit_cnt <= 5'h00;
        end else if (sclk_rise && !cs_s2) begin
            rx <= {rx[14:0], din_s2};
            bit_cnt <= (bit_cnt > isr_pkg::FRAME_LEN) ? bit_cnt : bit_cnt + 5'h01;
        end
    end

    // reply to a read comes in the following frame
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_addr <= 7'h00;
        end else if (frame_rd) begin
            rd_addr <= wr_addr;
        end
    end

    // transmit; a busy device shifts out zeros
    // msb stands from cs_n fall, so the opening sclk fall of a frame must not shift
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx <= isr_pkg::WORD_ZERO;
            dout <= 1'b0;
        end else if (cs_start) begin
            tx <= idle ? rd_word : isr_pkg::WORD_ZERO;
            dout <= idle ? rd_word[isr_pkg::FRAME_BITS-1] : 1'b0;
        end else if (sclk_fall && !cs_s2 && bit_cnt != 5'h00) begin
            tx <= {tx[14:0], 1'b0};
            dout <= tx[14];
        end
    end

    // flash-backed registers; identity words take no host writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            date_md <= isr_pkg::WORD_ZERO;
            date_y <= isr_pkg::WORD_ZERO;
            prod <= isr_pkg::WORD_ZERO;
            serial <= isr_pkg::WORD_ZERO;
            scr <= '0;
            fcnt <= 32'h0000_0000;
        end else if (st == isr_pkg::ST_LOAD) begin
            date_md <= DATE_MD;
            date_y <= DATE_Y;
            prod <= PRODUCT_CODE;
            serial <= LOT_SERIAL;
            for (int i = 0; i < isr_pkg::NUM_SCR; i++) begin
                scr[i] <= nv_scr[i];
            end
            fcnt <= nv_fcnt;
        end else if (start_update) begin
            fcnt <= fcnt_inc;
        end else if (frame_wr) begin
            for (int i = 0; i < isr_pkg::NUM_SCR; i++) begin
                if (wr_word == 7'(isr_pkg::ADDR_SCR_A + 7'(2 * i))) begin
                    if (wr_addr[0]) scr[i][15:8] <= wr_byte;
                    else scr[i][7:0] <= wr_byte;
                end
            end
        end
    end

    // store copies written only by the update command
    always_ff @(posedge clk) begin
        if (start_update) begin
            for (int i = 0; i < isr_pkg::NUM_SCR; i++) begin
                nv_scr[i] <= scr[i];
            end
            nv_fcnt <= fcnt_inc;
        end
    end

    AST_MONTH: assert property (@(posedge clk) disable iff (!nrst)
        idle && $past(idle) |-> date_md[15:8] == DATE_MD[15:8] && $stable(date_md[15:8]))
        else $error("month byte wrong");
    AST_DAY: assert property (@(posedge clk) disable iff (!nrst)
        idle && rd_addr == isr_pkg::ADDR_DATE_MD |-> rd_word[7:0] == DATE_MD[7:0])
        else $error("day byte wrong");
    AST_YEAR: assert property (@(posedge clk) disable iff (!nrst)
        idle && rd_addr[6:1] == isr_pkg::ADDR_DATE_Y[6:1] |-> rd_word == DATE_Y)
        else $error("year word wrong");
    AST_PROD: assert property (@(posedge clk) disable iff (!nrst)
        st != isr_pkg::ST_LOAD |-> prod == PRODUCT_CODE)
        else $error("product code wrong");
    AST_SERIAL: assert property (@(posedge clk) disable iff (!nrst)
        idle && rd_addr == isr_pkg::ADDR_SERIAL |-> rd_word == LOT_SERIAL)
        else $error("serial wrong");
    AST_SCR_WRITE: assert property (@(posedge clk) disable iff (!nrst)
        frame_wr && wr_addr == isr_pkg::ADDR_SCR_B |=> scr[1][7:0] == $past(wr_byte)
        && scr[0] == $past(scr[0]) && scr[2] == $past(scr[2]))
        else $error("scratch write lost or spread");
    AST_CNT_INC: assert property (@(posedge clk) disable iff (!nrst)
        idle ##1 start_update |=> fcnt == $past(fcnt) + CNT_ONE_L ##1 $stable(fcnt))
        else $error("flash counter step wrong");
    AST_CNT_MAP: assert property (@(posedge clk) disable iff (!nrst)
        rd_addr == isr_pkg::ADDR_FC_HI |-> rd_word == fcnt[31:16])
        else $error("counter high word map wrong");
    AST_BUSY_IGNORE: assert property (@(posedge clk) disable iff (!nrst)
        st == isr_pkg::ST_UPDATE ##1 st == isr_pkg::ST_UPDATE |-> $stable(scr)
        && $stable(rd_addr) && cmd_busy)
        else $error("request taken while busy");
    AST_RO_WRITE: assert property (@(posedge clk) disable iff (!nrst)
        frame_wr && wr_word == isr_pkg::ADDR_PROD |=> $stable(prod) && $stable(fcnt))
        else $error("read-only word changed");
    AST_LOAD: assert property (@(posedge clk) disable iff (!nrst)
        nrst && st == isr_pkg::ST_LOAD |=> idle && scr[0] == nv_scr[0] && fcnt == nv_fcnt)
        else $error("load after reset wrong");
endmodule : isr_bank

// ---- isr_host_model.sv ----
`timescale 1ns/1ps
module isr_host_model (
    input wire logic clk, // core clock
    output logic sclk, // serial clock, idles high
    output logic cs_n, // chip select, active low
    output logic din, // serial data to device
    input wire logic dout // serial data from device
);
    localparam int HALF = 6;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // one frame, msb first; din flips when idle so a stale level never helps
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (HALF) @(posedge clk);
            sclk <= 1'b0;
            din <= tx[i];
            repeat (HALF) @(posedge clk);
            sclk <= 1'b1;
            #1 rx[i] = dout;
        end
        repeat (HALF) @(posedge clk);
        cs_n <= 1'b1;
        din <= ~tx[0];
        repeat (8) @(posedge clk);
    endtask : xfer
    // word write: even byte first, then odd byte
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] r;
        xfer({1'b1, a, d[7:0]}, r);
        xfer({1'b1, a | 7'h01, d[15:8]}, r);
    endtask : wr
endmodule : isr_host_model

// ---- isr_pkg.sv ----
package isr_pkg;
    // register byte addresses; a 16-bit register spans this and the next byte
    localparam logic [6:0] ADDR_CMD = 7'h68;
    localparam logic [6:0] ADDR_DATE_MD = 7'h6e;
    localparam logic [6:0] ADDR_DATE_Y = 7'h70;
    localparam logic [6:0] ADDR_PROD = 7'h72;
    localparam logic [6:0] ADDR_SERIAL = 7'h74;
    localparam logic [6:0] ADDR_SCR_A = 7'h76;
    localparam logic [6:0] ADDR_SCR_B = 7'h78;
    localparam logic [6:0] ADDR_SCR_C = 7'h7a;
    localparam logic [6:0] ADDR_FC_LO = 7'h7c;
    localparam logic [6:0] ADDR_FC_HI = 7'h7e;
    localparam int NUM_SCR = 3;
    // serial frame layout
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam int WR_FLAG_BIT = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 8;
    localparam int CMD_FLASH_BIT = 3;
    // flash update duration
    localparam int CLK_MHZ = 250;
    localparam int FLASH_UPDATE_US = 1000;
    localparam int FLASH_UPDATE_CYCLES = FLASH_UPDATE_US * CLK_MHZ;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;
    typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_UPDATE} isr_state_type;
endpackage : isr_pkg
